// ===== hbp_pkg.sv
package hbp_pkg;

   // ****************************************************
   // clock and timing
   // ****************************************************
   localparam int CLK_HZ           = 20_000_000;
   localparam int CLK_PERIOD_NS    = 50;
   localparam int FREQ_LOW_HZ      = 80;
   localparam int FREQ_MID_HZ      = 100;
   localparam int FREQ_HIGH_HZ     = 200;
   localparam int PERIOD_LOW_CYC   = CLK_HZ / FREQ_LOW_HZ;
   localparam int PERIOD_MID_CYC   = CLK_HZ / FREQ_MID_HZ;
   localparam int PERIOD_HIGH_CYC  = CLK_HZ / FREQ_HIGH_HZ;
   localparam int HL_DEAD_NS       = 1000;
   localparam int LH_DEAD_NS       = 1000;
   localparam int HL_DEAD_CYC      = (HL_DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LH_DEAD_CYC      = (LH_DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ****************************************************
   // sizes
   // ****************************************************
   localparam int NUM_BRIDGES      = 6;
   localparam int NUM_CHANNELS     = 3;
   localparam int CNT_W            = 18;
   localparam int DEAD_W           = 8;

   // ****************************************************
   // frequency codes
   // ****************************************************
   localparam logic [1:0] FREQ_STOP = 2'h0;
   localparam logic [1:0] FREQ_LOW  = 2'h1;
   localparam logic [1:0] FREQ_MID  = 2'h2;
   localparam logic [1:0] FREQ_HIGH = 2'h3;

   // ****************************************************
   // command selectors and reset values
   // ****************************************************
   localparam logic [3:0] SEL_ACTIVATION = 4'h0;
   localparam logic [3:0] SEL_ASSIGN     = 4'h1;
   localparam logic [3:0] SEL_FREEWHEEL  = 4'h2;
   localparam logic [3:0] SEL_DUTY1      = 4'h3;
   localparam logic [3:0] SEL_DUTY2      = 4'h4;
   localparam logic [3:0] SEL_DUTY3      = 4'h5;
   localparam logic [3:0] SEL_FREQUENCY  = 4'h6;
   localparam logic [3:0] SEL_STATUS     = 4'h7;
   localparam logic [5:0] ACT_RESET      = 6'h00;
   localparam logic [11:0] ASSIGN_RESET  = 12'h000;
   localparam logic [5:0] FW_RESET       = 6'h00;
   localparam logic [7:0] DUTY_RESET     = 8'h00;
   localparam logic [5:0] FREQ_RESET     = 6'h00;

   typedef struct packed {
      logic [5:0]      high_act;
      logic [5:0]      low_act;
      logic [5:0][1:0] chan_sel;
      logic [5:0]      fw_active;
      logic [2:0][7:0] duty;
      logic [2:0][1:0] freq;
   } hbp_cfg_t;

endpackage

// ===== hbp_pwm_channel.sv
`timescale 1ns/1ps
`default_nettype none

module hbp_pwm_channel
   import hbp_pkg::*;
#(
   parameter int P_LOW  = PERIOD_LOW_CYC,
   parameter int P_MID  = PERIOD_MID_CYC,
   parameter int P_HIGH = PERIOD_HIGH_CYC
)
(
   input  wire logic       clk_in,      // system clock
   input  wire logic       rstn_in,     // async reset, low
   input  wire logic       clr_in,      // sync clear (sleep)
   input  wire logic [1:0] freq_in,     // frequency code
   input  wire logic [7:0] duty_in,     // duty value
   output logic            pwm_out,     // channel waveform
   output logic            running_out  // period running
);

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] on_reg;
   logic [CNT_W-1:0] per_reg;
   logic [CNT_W-1:0] new_per;
   logic [CNT_W-1:0] new_on;
   logic [CNT_W+7:0] prod;

   function automatic logic [CNT_W-1:0] period_of(input logic [1:0] code);
      case (code)
         FREQ_LOW:  period_of = CNT_W'(P_LOW);
         FREQ_MID:  period_of = CNT_W'(P_MID);
         FREQ_HIGH: period_of = CNT_W'(P_HIGH);
         default:   period_of = CNT_W'(P_HIGH);
      endcase
   endfunction

   // period and on-time are sampled only at a period boundary; code 00 stops the channel at once
   always_comb
   begin
      new_per = period_of(freq_in);
      prod    = new_per * duty_in;
      new_on  = prod[CNT_W+7:8];                                     // RL20
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         cnt_reg     <= '0;
         on_reg      <= '0;
         per_reg     <= '0;
         pwm_out     <= 1'b0;
         running_out <= 1'b0;
      end
      else if (clr_in || freq_in == FREQ_STOP)                        // RL11
      begin
         cnt_reg     <= '0;
         pwm_out     <= 1'b0;
         running_out <= 1'b0;
      end
      else if (!running_out || cnt_reg == per_reg - CNT_W'(1))        // RL12 RL13
      begin
         cnt_reg     <= '0;
         per_reg     <= new_per;
         on_reg      <= new_on;
         pwm_out     <= (new_on != '0);
         running_out <= 1'b1;
      end
      else
      begin
         cnt_reg <= cnt_reg + CNT_W'(1);
         pwm_out <= ((cnt_reg + CNT_W'(1)) < on_reg);                 // RL20
      end
   end

endmodule

`default_nettype wire

// ===== hbp_bridge_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// [RL1] supply power-on clears all, outputs off
// [RL2] enable high: normal mode, configurable
// [RL3] enable low: sleep, outputs off, settings reset
// [RL4] supply low: no commands, logic cleared
// [RL5] supply reset clears reset-occurred flag
// [RL6] enable reset also reported by flag
// [RL7] load supply loss keeps stored settings
// [RL8] each switch continuous or PWM driven
// [RL9] three channels, 8-bit duty, any assignment
// [RL10] codes 01/10/11 give 80/100/200 Hz
// [RL11] code 00 stops channel
// [RL12] non-zero code starts the period
// [RL13] running changes apply without glitches
// [RL14] freewheel active or passive, passive default
// [RL15] active freewheel drives complement after dead time
// [RL16] stopped active freewheel: high low, low on
// [RL17] two-bit assignment per bridge, 00 both off; the code drives a 00 bridge continuously from its activation bits
// [RL18] host order for single outputs
// [RL19] host activates paralleled outputs before frequency
// [RL20] on-time proportional to duty, zero none

module hbp_bridge_ctrl
   import hbp_pkg::*;
#(
   parameter int PER_LOW  = PERIOD_LOW_CYC,
   parameter int PER_MID  = PERIOD_MID_CYC,
   parameter int PER_HIGH = PERIOD_HIGH_CYC
)
(
   input  wire logic        MCLK_IN,                 // 20 MHz clock
   input  wire logic        RSTN_IN,                 // logic supply reset, low
   input  wire logic        EN_IN,                   // enable, high = normal
   input  wire logic        VS_OK_IN,                // load supply valid
   input  wire logic        CMD_WR_IN,               // command write strobe
   input  wire logic [3:0]  CMD_SEL_IN,              // command selector
   input  wire logic [15:0] CMD_DATA_IN,             // command data
   output logic             CMD_ACCEPT_OUT,          // write taken
   output logic             NORMAL_MODE_OUT,         // normal mode
   output logic             CHARGE_PUMP_EN_OUT,      // charge pump on
   output logic             RESET_OCCURRED_FLAG_N_OUT, // 0 after reset
   output logic [2:0]       CHANNEL_RUNNING_OUT,     // channel running
   output logic [5:0]       HIGH_SIDE_SWITCH_OUT,    // high side gates
   output logic [5:0]       LOW_SIDE_SWITCH_OUT      // low side gates
);

   // ****************************************************
   // mode
   // ****************************************************
   logic              normal_reg;
   logic              wr_ok;
   logic              drive_ok;

   always_ff @(posedge MCLK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         normal_reg <= 1'b0;                                         // RL4
      end
      else
      begin
         normal_reg <= EN_IN;                                        // RL2 RL3
      end
   end

   always_comb
   begin
      wr_ok    = CMD_WR_IN && normal_reg && EN_IN;                   // RL4
      drive_ok = normal_reg && EN_IN && VS_OK_IN;                    // RL7
   end

   assign CMD_ACCEPT_OUT     = wr_ok;
   assign NORMAL_MODE_OUT    = normal_reg;
   assign CHARGE_PUMP_EN_OUT = normal_reg;                           // RL2

   // ****************************************************
   // settings
   // ****************************************************
   logic [5:0]        high_act_reg;
   logic [5:0]        low_act_reg;
   logic [11:0]       assign_reg;
   logic [5:0]        fw_reg;
   logic [2:0][7:0]   duty_reg;
   logic [5:0]        freq_reg;
   logic              flag_n_reg;
   hbp_cfg_t          cfg;

   function automatic logic hit(input logic [3:0] sel);
      hit = wr_ok && (CMD_SEL_IN == sel);
   endfunction

   always_ff @(posedge MCLK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         high_act_reg <= ACT_RESET;                                  // RL1
         low_act_reg  <= ACT_RESET;
      end
      else if (!EN_IN)
      begin
         high_act_reg <= ACT_RESET;                                  // RL3
         low_act_reg  <= ACT_RESET;
      end
      else if (hit(SEL_ACTIVATION))
      begin
         high_act_reg <= CMD_DATA_IN[5:0];                           // RL8
         low_act_reg  <= CMD_DATA_IN[11:6];
      end
   end

   always_ff @(posedge MCLK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         assign_reg <= ASSIGN_RESET;
      end
      else if (!EN_IN)
      begin
         assign_reg <= ASSIGN_RESET;                                 // RL3
      end
      else if (hit(SEL_ASSIGN))
      begin
         assign_reg <= CMD_DATA_IN[11:0];                            // RL17
      end
   end

   always_ff @(posedge MCLK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         fw_reg <= FW_RESET;                                         // RL14
      end
      else if (!EN_IN)
      begin
         fw_reg <= FW_RESET;                                         // RL14
      end
      else if (hit(SEL_FREEWHEEL))
      begin
         fw_reg <= CMD_DATA_IN[5:0];                                 // RL14
      end
   end

   always_ff @(posedge MCLK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         duty_reg <= {3{DUTY_RESET}};
      end
      else if (!EN_IN)
      begin
         duty_reg <= {3{DUTY_RESET}};                                // RL3
      end
      else if (hit(SEL_DUTY1))
      begin
         duty_reg[0] <= CMD_DATA_IN[7:0];                            // RL9
      end
      else if (hit(SEL_DUTY2))
      begin
         duty_reg[1] <= CMD_DATA_IN[7:0];                            // RL9
      end
      else if (hit(SEL_DUTY3))
      begin
         duty_reg[2] <= CMD_DATA_IN[7:0];                            // RL9
      end
   end

   always_ff @(posedge MCLK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         freq_reg <= FREQ_RESET;
      end
      else if (!EN_IN)
      begin
         freq_reg <= FREQ_RESET;                                     // RL3
      end
      else if (hit(SEL_FREQUENCY))
      begin
         freq_reg <= CMD_DATA_IN[5:0];                               // RL10
      end
   end

   // flag is only raised by the host; any reset drops it
   always_ff @(posedge MCLK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         flag_n_reg <= 1'b0;                                         // RL5
      end
      else if (!EN_IN)
      begin
         flag_n_reg <= 1'b0;                                         // RL6
      end
      else if (hit(SEL_STATUS) && CMD_DATA_IN[0])
      begin
         flag_n_reg <= 1'b1;
      end
   end

   assign RESET_OCCURRED_FLAG_N_OUT = flag_n_reg;

   always_comb
   begin
      cfg.high_act  = high_act_reg;
      cfg.low_act   = low_act_reg;
      cfg.chan_sel  = assign_reg;
      cfg.fw_active = fw_reg;
      cfg.duty      = duty_reg;
      cfg.freq      = freq_reg;
   end

   // ****************************************************
   // pwm channels
   // ****************************************************
   logic [2:0]        ch_pwm;
   logic [2:0]        ch_run;

   genvar c;
   generate
      for (c = 0; c < NUM_CHANNELS; c++)
      begin : g_ch
         hbp_pwm_channel #(
            .P_LOW  (PER_LOW),
            .P_MID  (PER_MID),
            .P_HIGH (PER_HIGH)
         ) u_ch (
            .clk_in      (MCLK_IN),
            .rstn_in     (RSTN_IN),
            .clr_in      (!EN_IN),
            .freq_in     (cfg.freq[c]),                              // RL10
            .duty_in     (cfg.duty[c]),
            .pwm_out     (ch_pwm[c]),
            .running_out (ch_run[c])
         );
      end
   endgenerate

   assign CHANNEL_RUNNING_OUT = ch_run;

   // ****************************************************
   // bridges
   // ****************************************************
   logic [5:0]        hs_want;
   logic [5:0]        ls_want;
   logic [5:0]        hs_reg;
   logic [5:0]        ls_reg;

   genvar b;
   generate
      for (b = 0; b < NUM_BRIDGES; b++)
      begin : g_br
         logic [1:0]        sel;
         logic              pwm;
         logic              run;
         logic              fw;
         logic              ha;
         logic              la;
         logic [DEAD_W-1:0] dead_reg;

         always_comb
         begin
            sel = cfg.chan_sel[b];
            fw  = cfg.fw_active[b];
            ha  = cfg.high_act[b];
            la  = cfg.low_act[b];
            pwm = 1'b0;
            run = 1'b0;
            if (sel != 2'h0)
            begin
               pwm = ch_pwm[sel - 2'h1];                             // RL9
               run = ch_run[sel - 2'h1];
            end
            hs_want[b] = 1'b0;
            ls_want[b] = 1'b0;
            if (sel == 2'h0)
            begin
               hs_want[b] = ha;                                      // RL8
               ls_want[b] = la && !ha;
            end
            else if (ha)
            begin
               hs_want[b] = run && pwm;                              // RL8
               ls_want[b] = fw && !(run && pwm);                     // RL15 RL16
            end
            else if (la)
            begin
               ls_want[b] = run && pwm;
               hs_want[b] = fw && !(run && pwm);                     // RL15
            end
         end

         // a switch may close only after both were open for a dead time
         always_ff @(posedge MCLK_IN or negedge RSTN_IN)
         begin
            if (!RSTN_IN)
            begin
               hs_reg[b] <= 1'b0;                                    // RL1
               ls_reg[b] <= 1'b0;
               dead_reg  <= '0;
            end
            else if (!drive_ok)
            begin
               hs_reg[b] <= 1'b0;                                    // RL3 RL7
               ls_reg[b] <= 1'b0;
               dead_reg  <= '0;
            end
            else
            begin
               if (!hs_want[b] || !ls_want[b] && hs_reg[b])
               begin
                  hs_reg[b] <= hs_want[b] && hs_reg[b];
               end
               if (hs_reg[b] || ls_reg[b])
               begin
                  dead_reg <= '0;
               end
               else if (dead_reg != {DEAD_W{1'b1}})
               begin
                  dead_reg <= dead_reg + DEAD_W'(1);
               end
               if (!hs_want[b])
               begin
                  hs_reg[b] <= 1'b0;
               end
               else if (!ls_reg[b] && !ls_want[b] &&
                        dead_reg >= DEAD_W'(LH_DEAD_CYC))
               begin
                  hs_reg[b] <= 1'b1;                                 // RL15
               end
               if (!ls_want[b])
               begin
                  ls_reg[b] <= 1'b0;
               end
               else if (!hs_reg[b] && !hs_want[b] &&
                        dead_reg >= DEAD_W'(HL_DEAD_CYC))
               begin
                  ls_reg[b] <= 1'b1;                                 // RL15
               end
            end
         end
      end
   endgenerate

   assign HIGH_SIDE_SWITCH_OUT = hs_reg;
   assign LOW_SIDE_SWITCH_OUT  = ls_reg;

endmodule

`default_nettype wire

// ===== hbp_checker.sv
`timescale 1ns/1ps
`default_nettype none
module hbp_checker
   import hbp_pkg::*;
#(
   parameter int PER_LOW  = PERIOD_LOW_CYC,
   parameter int PER_MID  = PERIOD_MID_CYC,
   parameter int PER_HIGH = PERIOD_HIGH_CYC
)
(
   input wire logic        MCLK_IN,                   // clock
   input wire logic        RSTN_IN,                   // reset, low
   input wire logic        EN_IN,                     // enable
   input wire logic        VS_OK_IN,                  // load supply ok
   input wire logic        CMD_WR_IN,                 // write strobe
   input wire logic [3:0]  CMD_SEL_IN,                // selector
   input wire logic [15:0] CMD_DATA_IN,               // data
   input wire logic        CMD_ACCEPT_OUT,            // write taken
   input wire logic        NORMAL_MODE_OUT,           // normal mode
   input wire logic        CHARGE_PUMP_EN_OUT,        // pump on
   input wire logic        RESET_OCCURRED_FLAG_N_OUT, // reset flag
   input wire logic [2:0]  CHANNEL_RUNNING_OUT,       // running
   input wire logic [5:0]  HIGH_SIDE_SWITCH_OUT,      // high gates
   input wire logic [5:0]  LOW_SIDE_SWITCH_OUT        // low gates
);
   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (!RSTN_IN);

   // cycles with both switches of bridge 1 open
   logic [7:0] quiet_reg;
   always_ff @(posedge MCLK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
         quiet_reg <= 8'hff;
      else if (HIGH_SIDE_SWITCH_OUT[0] || LOW_SIDE_SWITCH_OUT[0])
         quiet_reg <= 8'h00;
      else if (quiet_reg != 8'hff)
         quiet_reg <= quiet_reg + 8'h01;
   end

   a_reset_clears: assert property ($rose(RSTN_IN) |->
      {HIGH_SIDE_SWITCH_OUT, LOW_SIDE_SWITCH_OUT} == 12'h000 && !RESET_OCCURRED_FLAG_N_OUT)
      else $error("outputs or flag not cleared by reset");
   a_accept_gate: assert property (CMD_ACCEPT_OUT == (CMD_WR_IN && NORMAL_MODE_OUT && EN_IN))
      else $error("write acceptance wrong");
   a_mode_follows: assert property ($past(RSTN_IN) |-> NORMAL_MODE_OUT == $past(EN_IN))
      else $error("mode does not follow enable");
   a_pump_mode: assert property (CHARGE_PUMP_EN_OUT == NORMAL_MODE_OUT)
      else $error("charge pump differs from mode");
   a_sleep_clears: assert property (!EN_IN |=>
      {HIGH_SIDE_SWITCH_OUT, LOW_SIDE_SWITCH_OUT} == 12'h000 && !RESET_OCCURRED_FLAG_N_OUT
      && CHANNEL_RUNNING_OUT == 3'h0) else $error("sleep left state behind");
   a_supply_off: assert property (!VS_OK_IN |=> (HIGH_SIDE_SWITCH_OUT | LOW_SIDE_SWITCH_OUT) == 6'h00)
      else $error("switch on without load supply");
   a_no_overlap: assert property ((HIGH_SIDE_SWITCH_OUT & LOW_SIDE_SWITCH_OUT) == 6'h00)
      else $error("both switches of a bridge on");
   a_dead_high: assert property ($rose(HIGH_SIDE_SWITCH_OUT[0]) |-> quiet_reg >= 8'(LH_DEAD_CYC - 2))
      else $error("high switch closed inside dead time");
   a_dead_low: assert property ($rose(LOW_SIDE_SWITCH_OUT[0]) |-> quiet_reg >= 8'(HL_DEAD_CYC - 2))
      else $error("low switch closed inside dead time");
   a_stop_halts: assert property (CMD_ACCEPT_OUT && CMD_SEL_IN == SEL_FREQUENCY
      && CMD_DATA_IN[1:0] == FREQ_STOP |-> ##2 !CHANNEL_RUNNING_OUT[0]) else $error("channel kept running");
   a_start_runs: assert property (CMD_ACCEPT_OUT && CMD_SEL_IN == SEL_FREQUENCY
      && CMD_DATA_IN[1:0] != FREQ_STOP |-> ##2 (CHANNEL_RUNNING_OUT[0] || !NORMAL_MODE_OUT))
      else $error("channel did not start");

   c_accept: cover property (CMD_ACCEPT_OUT);
   c_run: cover property ($rose(CHANNEL_RUNNING_OUT[0]));
   c_fw: cover property ($rose(LOW_SIDE_SWITCH_OUT[0]) && CHANNEL_RUNNING_OUT[0]);
endmodule

bind hbp_bridge_ctrl hbp_checker #(.PER_LOW(PER_LOW), .PER_MID(PER_MID), .PER_HIGH(PER_HIGH)) hbp_checker_inst (
   .MCLK_IN(MCLK_IN), .RSTN_IN(RSTN_IN), .EN_IN(EN_IN), .VS_OK_IN(VS_OK_IN), .CMD_WR_IN(CMD_WR_IN),
   .CMD_SEL_IN(CMD_SEL_IN), .CMD_DATA_IN(CMD_DATA_IN), .CMD_ACCEPT_OUT(CMD_ACCEPT_OUT),
   .NORMAL_MODE_OUT(NORMAL_MODE_OUT), .CHARGE_PUMP_EN_OUT(CHARGE_PUMP_EN_OUT),
   .RESET_OCCURRED_FLAG_N_OUT(RESET_OCCURRED_FLAG_N_OUT), .CHANNEL_RUNNING_OUT(CHANNEL_RUNNING_OUT),
   .HIGH_SIDE_SWITCH_OUT(HIGH_SIDE_SWITCH_OUT), .LOW_SIDE_SWITCH_OUT(LOW_SIDE_SWITCH_OUT));
`default_nettype wire

// ===== hbp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hbp_host_model
   import hbp_pkg::*;
(
   input  wire logic        clk_in,  // clock
   output logic             wr_out,  // write strobe
   output logic [3:0]       sel_out, // selector
   output logic [15:0]      data_out // data
);
   logic [15:0] exp_q[$];

   initial
   begin
      wr_out = 1'b0;
      sel_out = 4'h0;
      data_out = 16'h0000;
   end

   // one write, with the expected acceptance noted first
   task automatic put(input logic [3:0] s, input logic [15:0] d, input logic ok);
      @(posedge clk_in);
      #1;
      exp_q.push_back({15'h0000, ok});
      wr_out = 1'b1;
      sel_out = s;
      data_out = d;
      @(posedge clk_in);
      #1;
      wr_out = 1'b0;
      sel_out = ~s;
      data_out = ~d;
   endtask

   task automatic pwm_seq(input int ch, input logic [5:0] fw, input logic [11:0] asg, input logic [7:0] duty,
                          input logic [1:0] code, input logic [11:0] act, input logic par);
      put(SEL_FREQUENCY, 16'h0000, 1'b1);
      put(SEL_FREEWHEEL, {10'h000, fw}, 1'b1);
      put(SEL_ASSIGN, {4'h0, asg}, 1'b1);
      put(SEL_DUTY1 + 4'(ch), {8'h00, duty}, 1'b1);
      if (par)
         put(SEL_ACTIVATION, {4'h0, act}, 1'b1);
      put(SEL_FREQUENCY, {10'h000, 6'(code) << (2 * ch)}, 1'b1);
      if (!par)
         put(SEL_ACTIVATION, {4'h0, act}, 1'b1);
   endtask
endmodule
`default_nettype wire

// ===== tb_half_bridge_pwm_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_half_bridge_pwm_control
   import hbp_pkg::*;
;
   localparam int PL = 512;
   localparam int PM = 400;
   localparam int PH = 200;
   logic        mclk, rstn, en, vs_ok, wr, probe, accept, normal, pump, flag_n;
   logic [3:0]  sel;
   logic [15:0] data, note;
   logic [2:0]  running;
   logic [5:0]  hs, ls;
   logic [31:0] seed;
   logic [7:0]  duty;
   int          err_count, checked, on, rises, lon, diff, per, exp_on;

   hbp_host_model hbp_host_model_inst (.clk_in(mclk), .wr_out(wr), .sel_out(sel), .data_out(data));
   hbp_bridge_ctrl #(.PER_LOW(PL), .PER_MID(PM), .PER_HIGH(PH)) hbp_bridge_ctrl_inst (
      .MCLK_IN(mclk), .RSTN_IN(rstn), .EN_IN(en), .VS_OK_IN(vs_ok), .CMD_WR_IN(wr), .CMD_SEL_IN(sel),
      .CMD_DATA_IN(data), .CMD_ACCEPT_OUT(accept), .NORMAL_MODE_OUT(normal), .CHARGE_PUMP_EN_OUT(pump),
      .RESET_OCCURRED_FLAG_N_OUT(flag_n), .CHANNEL_RUNNING_OUT(running), .HIGH_SIDE_SWITCH_OUT(hs),
      .LOW_SIDE_SWITCH_OUT(ls));

   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic expect_sw(input logic [5:0] h, input logic [5:0] l);
      hbp_host_model_inst.exp_q.push_back({4'h0, h, l});
      probe = 1'b1;
      tick(1);
      probe = 1'b0;
   endtask

   task automatic measure(input int n);
      logic last;
      on = 0;
      rises = 0;
      lon = 0;
      diff = 0;
      last = hs[0];
      repeat (n)
      begin
         tick(1);
         on += int'(hs[0]);
         lon += int'(ls[0]);
         diff += int'(hs[0] != hs[1]);
         rises += int'(hs[0] && !last);
         last = hs[0];
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // oldest note against what the outputs show now
   always @(negedge mclk)
   begin
      if ((wr === 1'b1 || probe === 1'b1) && hbp_host_model_inst.exp_q.size() > 0)
      begin
         note = hbp_host_model_inst.exp_q.pop_front();
         if (probe === 1'b1)
            check({4'h0, hs, ls}, note);
         else
            check({15'h0000, accept}, note);
      end
   end

   initial
   begin
      #(20000 * CLK_PERIOD_NS);
      err_count++;
      give_verdict();
   end

   initial
   begin
      rstn = 1'b0;
      en = 1'b0;
      vs_ok = 1'b1;
      probe = 1'b0;
      err_count = 0;
      checked = 0;
      seed = 32'h0000_0047;
      tick(10);
      rstn = 1'b1;
      expect_sw(6'h00, 6'h00);
      check({15'h0000, flag_n}, 16'h0000);
      hbp_host_model_inst.put(SEL_ACTIVATION, 16'(rnd()), 1'b0);
      en = 1'b1;
      hbp_host_model_inst.put(SEL_ACTIVATION, 16'h0081, 1'b1);
      tick(25);
      expect_sw(6'h01, 6'h02);
      check({14'h0000, normal, pump}, 16'h0003);
      vs_ok = 1'b0;
      tick(2);
      expect_sw(6'h00, 6'h00);
      vs_ok = 1'b1;
      tick(25);
      expect_sw(6'h01, 6'h02);
      $display("test continuous done");
      hbp_host_model_inst.put(SEL_STATUS, 16'h0001, 1'b1);
      tick(2);
      check({15'h0000, flag_n}, 16'h0001);
      en = 1'b0;
      tick(3);
      expect_sw(6'h00, 6'h00);
      check({14'h0000, normal, pump}, 16'h0000);
      en = 1'b1;
      tick(25);
      expect_sw(6'h00, 6'h00);
      check({15'h0000, flag_n}, 16'h0000);
      $display("test sleep done");
      for (int i = 0; i < 3; i++)
      begin
         duty = 8'(rnd() % 200);
         per = (i == 0) ? PL : ((i == 1) ? PM : PH);
         exp_on = per * int'(duty) / 256;
         hbp_host_model_inst.pwm_seq(i, 6'h00, 12'(i + 1), duty, 2'(i + 1), 12'h001, 1'b0);
         tick(2 * per);
         measure(per);
         check(16'(on), 16'(exp_on));
         check(16'(rises), 16'(exp_on != 0));
      end
      hbp_host_model_inst.put(SEL_FREQUENCY, 16'h0000, 1'b1);
      tick(3);
      check({13'h0000, running}, 16'h0000);
      expect_sw(6'h00, 6'h00);
      $display("test channels done");
      hbp_host_model_inst.pwm_seq(0, 6'h01, 12'h001, 8'h80, FREQ_STOP, 12'h001, 1'b0);
      tick(25);
      expect_sw(6'h00, 6'h01);
      hbp_host_model_inst.pwm_seq(0, 6'h01, 12'h001, 8'h80, FREQ_HIGH, 12'h001, 1'b0);
      tick(2 * PH);
      measure(PH);
      check(16'(lon != 0), 16'h0001);
      hbp_host_model_inst.pwm_seq(1, 6'h00, 12'h00a, 8'h40, FREQ_HIGH, 12'h003, 1'b1);
      tick(2 * PH);
      measure(PH);
      check(16'(diff), 16'h0000);
      check(16'(on), 16'(PH * 64 / 256));
      hbp_host_model_inst.pwm_seq(0, 6'h00, 12'h001, 8'h40, FREQ_HIGH, 12'h040, 1'b0);
      tick(2 * PH);
      measure(PH);
      check(16'(lon), 16'(PH * 64 / 256));
      check(16'(on), 16'h0000);
      hbp_host_model_inst.put(SEL_DUTY1, 16'h0080, 1'b1);
      tick(2 * PH);
      measure(PH);
      check(16'(lon), 16'(PH * 128 / 256));
      $display("test freewheel and parallel done");
      give_verdict();
   end
endmodule
`default_nettype wire
